//--- core/ipmc_top.sv
// Interrupt priority and mode control for DMA transfer-end and two serial channels
// Assumes peripheral requests and CPU mask state come from logic on mclk_i;
// NMI and standby arrive on pins and are synchronised here
`timescale 1ns/1ps
module ipmc_top
    import ipmc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic dma_ch0a_done_i,
    input wire logic dma_ch0b_done_i,
    input wire logic dma_ch1a_done_i,
    input wire logic dma_ch1b_done_i,
    input wire logic serial0_rx_error_i,
    input wire logic serial0_rx_full_i,
    input wire logic serial0_tx_empty_i,
    input wire logic serial0_tx_done_i,
    input wire logic serial1_rx_error_i,
    input wire logic serial1_rx_full_i,
    input wire logic serial1_tx_empty_i,
    input wire logic serial1_tx_done_i,
    input wire logic nmi_pin_i,
    input wire logic hw_standby_i,
    input wire logic cpu_global_mask_i,
    input wire logic cpu_user_bit_i,
    input wire logic [2:0] cpu_mask_level_i,
    input wire logic long_addr_mode_i,
    output logic irq_req_o,
    output logic [7:0] irq_vector_o,
    output logic [2:0] irq_level_o,
    output logic [15:0] vec_addr_o,
    output logic nmi_req_o,
    output logic int_o
);

    // =====================================================================
    // Declarations
    logic [7:0] sysctl_r;
    logic [7:0] pri10_r;
    logic [7:0] pri11_r;
    logic [11:0] en_r;
    logic [3:0] status_r;
    logic [3:0] status_nxt;
    logic [3:0] mask_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic nmi_s1_r;
    logic nmi_s2_r;
    logic stby_s1_r;
    logic stby_s2_r;
    logic nmi_req_r;
    logic irq_req_r;
    logic [7:0] vec_r;
    logic [7:0] vec_nxt;
    logic [2:0] lvl_r;
    logic [2:0] lvl_nxt;
    logic [15:0] addr_r;
    logic [11:0] src_raw;
    logic [11:0] src_en;
    logic mode_high;
    logic accept;
    logic nmi_now;
    logic [3:0] ev;
    logic wr_sysctl;
    ipmc_arb_if arb_bus ();

    // =====================================================================
    // Pin synchronisers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            nmi_s1_r <= 1'b0;
            nmi_s2_r <= 1'b0;
            stby_s1_r <= 1'b0;
            stby_s2_r <= 1'b0;
        end else begin
            nmi_s1_r <= nmi_pin_i;
            nmi_s2_r <= nmi_s1_r;
            stby_s1_r <= hw_standby_i;
            stby_s2_r <= stby_s1_r;
        end
    end

    // =====================================================================
    // Register writes
    assign wr_sysctl = reg_wr_i && (reg_addr_i == ADR_SYSCTL);

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sysctl_r <= RST_SYSCTL;
            pri10_r <= RST_PRI;
            pri11_r <= RST_PRI;
            en_r <= RST_EN;
            mask_r <= RST_EV;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADR_SYSCTL: sysctl_r <= reg_wdata_i;
                ADR_PRI10: pri10_r <= reg_wdata_i;
                ADR_PRI11: pri11_r <= reg_wdata_i;
                ADR_EN_LO: en_r[7:0] <= reg_wdata_i;
                ADR_EN_HI: en_r[11:8] <= reg_wdata_i[3:0];
                ADR_MASK: mask_r <= reg_wdata_i[3:0];
                default: begin
                end
            endcase
        end
    end

    // =====================================================================
    // Source gating and arbitration
    assign src_raw = {serial1_tx_done_i, serial1_tx_empty_i, serial1_rx_full_i,
                      serial1_rx_error_i, serial0_tx_done_i, serial0_tx_empty_i,
                      serial0_rx_full_i, serial0_rx_error_i, dma_ch1b_done_i,
                      dma_ch1a_done_i, dma_ch0b_done_i, dma_ch0a_done_i};
    assign src_en = src_raw & en_r;
    assign mode_high = sysctl_r[BIT_MODE_HIGH];

    assign arb_bus.req = src_en;
    assign arb_bus.lvl_dma = pri10_r[6:4];
    assign arb_bus.lvl_sci0 = pri10_r[2:0];
    assign arb_bus.lvl_sci1 = pri11_r[6:4];
    assign arb_bus.flat = !mode_high;

    ipmc_arbiter u_arb (
        .bus(arb_bus)
    );

    // =====================================================================
    // Acceptance
    assign nmi_now = nmi_s2_r && !stby_s2_r;

    always_comb begin
        if (mode_high) begin
            accept = arb_bus.hit && (arb_bus.lvl > cpu_mask_level_i);
        end else begin
            accept = arb_bus.hit && !cpu_global_mask_i;
        end
    end

    always_comb begin
        vec_nxt = 8'h00;
        lvl_nxt = 3'h0;
        if (nmi_now) begin
            vec_nxt = VEC_NMI;
            lvl_nxt = LVL_NMI;
        end else if (accept) begin
            vec_nxt = ipmc_vec_of(arb_bus.idx);
            lvl_nxt = arb_bus.lvl;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            nmi_req_r <= 1'b0;
            irq_req_r <= 1'b0;
            vec_r <= 8'h00;
            lvl_r <= 3'h0;
            addr_r <= 16'h0000;
        end else begin
            nmi_req_r <= nmi_now;
            irq_req_r <= accept;
            vec_r <= vec_nxt;
            lvl_r <= lvl_nxt;
            addr_r <= long_addr_mode_i ? {6'h00, vec_nxt, 2'b00} : {7'h00, vec_nxt, 1'b0};
        end
    end

    assign irq_req_o = irq_req_r;
    assign nmi_req_o = nmi_req_r;
    assign irq_vector_o = vec_r;
    assign irq_level_o = lvl_r;
    assign vec_addr_o = addr_r;

    // =====================================================================
    // Event status, cleared by read, set wins
    always_comb begin
        ev = 4'h0;
        ev[BIT_EV_NMI] = nmi_now && !nmi_req_r;
        ev[BIT_EV_IRQ] = accept && !irq_req_r;
        ev[BIT_EV_HELD] = arb_bus.hit && !accept;
        ev[BIT_EV_BADMODE] = wr_sysctl && reg_wdata_i[BIT_MODE_LOW];
        status_nxt = status_r;
        if (reg_rd_i && (reg_addr_i == ADR_STATUS)) begin
            status_nxt = 4'h0;
        end
        status_nxt = status_nxt | ev;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_r <= RST_EV;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign int_o = |(status_r & mask_r);

    // =====================================================================
    // Register reads
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADR_SYSCTL: rdata_nxt = sysctl_r;
                ADR_PRI10: rdata_nxt = pri10_r;
                ADR_PRI11: rdata_nxt = pri11_r;
                ADR_EN_LO: rdata_nxt = en_r[7:0];
                ADR_EN_HI: rdata_nxt = {4'h0, en_r[11:8]};
                ADR_STATUS: rdata_nxt = {4'h0, status_r};
                ADR_MASK: rdata_nxt = {4'h0, mask_r};
                ADR_VECTOR: rdata_nxt = vec_r;
                ADR_CPUVIEW: rdata_nxt = {cpu_user_bit_i, cpu_global_mask_i, irq_req_r,
                                          nmi_req_r, 1'b0, cpu_mask_level_i};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // =====================================================================
    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Four cycles cover both sync stages, also right after reset release
    sequence seq_nmi_held;
        (nmi_pin_i && !hw_standby_i) [*4];
    endsequence

    sequence seq_flat_open;
        !mode_high && !cpu_global_mask_i && !nmi_now;
    endsequence

    chk_dma_vectors: assert property (
        seq_flat_open and (src_en == 12'h001) |=> irq_req_o && (irq_vector_o == VEC_DMA_BASE))
        else $error("DMA source gave wrong vector");

    chk_sci0_vectors: assert property (
        seq_flat_open and (src_en[3:0] == 4'h0) && (src_en[7:4] != 4'h0)
        |=> (irq_vector_o >= VEC_SCI0_BASE) && (irq_vector_o < VEC_SCI1_BASE))
        else $error("Serial 0 vector out of range");

    chk_sci1_vectors: assert property (
        seq_flat_open and (src_en[7:0] == 8'h00) && (src_en[11:8] == 4'h8)
        |=> irq_vector_o == VEC_SCI1_BASE + 8'h03)
        else $error("Serial 1 vector wrong");

    chk_vector_addr: assert property (
        ##1 (vec_addr_o == ($past(long_addr_mode_i) ? {6'h00, irq_vector_o, 2'b00}
                                                    : {7'h00, irq_vector_o, 1'b0})))
        else $error("Vector address does not match vector");

    chk_nmi_pass: assert property (
        seq_nmi_held |=> nmi_req_o && (irq_vector_o == VEC_NMI))
        else $error("NMI not passed");

    chk_nmi_standby: assert property (
        hw_standby_i [*3] |=> !nmi_req_o)
        else $error("NMI passed during standby");

    chk_enable_gate: assert property (
        ((src_raw & en_r) == 12'h000) |=> !irq_req_o)
        else $error("Disabled source requested");

    chk_mode0_mask: assert property (
        !mode_high && cpu_global_mask_i |=> !irq_req_o)
        else $error("Masked request in mode 0");

    chk_mode2_level: assert property (
        mode_high && arb_bus.hit && (arb_bus.lvl <= cpu_mask_level_i) |=> !irq_req_o)
        else $error("Request at or below mask level accepted");

    chk_mode2_accept: assert property (
        irq_req_o && $past(mode_high) |-> irq_level_o > $past(cpu_mask_level_i))
        else $error("Accepted level not above mask");

    chk_tie_order: assert property (
        seq_flat_open and (src_en[1:0] == 2'b11) |=> irq_vector_o == VEC_DMA_BASE)
        else $error("Tie not resolved to lower vector");

    chk_status_sticky: assert property (
        (status_r != 4'h0) && !(reg_rd_i && (reg_addr_i == ADR_STATUS))
        |=> ((status_r & $past(status_r)) == $past(status_r)))
        else $error("Status bit lost without read");

    chk_nmi_shows_vec: assert property (
        nmi_req_o |-> (irq_vector_o == VEC_NMI) && (irq_level_o == LVL_NMI))
        else $error("NMI vector or level wrong");

    chk_nmi_follows: assert property (
        nmi_now |=> nmi_req_o)
        else $error("Synchronised NMI not passed");

    chk_enable_source: assert property (
        irq_req_o |-> $past(src_en) != 12'h000)
        else $error("Request without enabled source");

    chk_mode0_open: assert property (
        !mode_high && arb_bus.hit && !cpu_global_mask_i |=> irq_req_o)
        else $error("Unmasked request dropped in mode 0");

    chk_mode0_flat: assert property (
        !mode_high && arb_bus.hit && !nmi_now |=> irq_level_o == LVL_FLAT)
        else $error("Level used in mode 0");

    chk_mode2_open: assert property (
        mode_high && arb_bus.hit && (arb_bus.lvl > cpu_mask_level_i) |=> irq_req_o)
        else $error("Request above mask level dropped");

    chk_vector_window: assert property (
        irq_req_o && !nmi_req_o |-> (irq_vector_o >= VEC_DMA_BASE)
        && (irq_vector_o <= VEC_SCI1_BASE + 8'h03)
        && ((irq_vector_o < VEC_DMA_BASE + 8'h04) || (irq_vector_o >= VEC_SCI0_BASE)))
        else $error("Vector outside source ranges");

    chk_dma_level: assert property (
        mode_high && arb_bus.hit && (arb_bus.idx < SRC_SCI0_BASE)
        |-> arb_bus.lvl == pri10_r[6:4])
        else $error("DMA level not from tenth register");

    chk_sci1_level: assert property (
        mode_high && arb_bus.hit && (arb_bus.idx >= SRC_SCI1_BASE)
        |-> arb_bus.lvl == pri11_r[6:4])
        else $error("Serial 1 level not from eleventh register");

endmodule : ipmc_top

//--- core/ipmc_pkg.sv
// Constants, register map and source decode for the interrupt priority controller
// Assumes one system clock; all users import the whole package
package ipmc_pkg;

    // =====================================================================
    // Sources
    localparam int NSRC = 12;
    localparam logic [3:0] SRC_SCI0_BASE = 4'h4;
    localparam logic [3:0] SRC_SCI1_BASE = 4'h8;

    // =====================================================================
    // Vector numbers and levels
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [7:0] VEC_DMA_BASE = 8'h48;
    localparam logic [7:0] VEC_SCI0_BASE = 8'h50;
    localparam logic [7:0] VEC_SCI1_BASE = 8'h54;
    localparam logic [2:0] LVL_NMI = 3'h7;
    localparam logic [2:0] LVL_FLAT = 3'h0;

    // =====================================================================
    // Register indices
    localparam logic [3:0] ADR_SYSCTL = 4'h0;
    localparam logic [3:0] ADR_PRI10 = 4'h1;
    localparam logic [3:0] ADR_PRI11 = 4'h2;
    localparam logic [3:0] ADR_EN_LO = 4'h3;
    localparam logic [3:0] ADR_EN_HI = 4'h4;
    localparam logic [3:0] ADR_STATUS = 4'h5;
    localparam logic [3:0] ADR_MASK = 4'h6;
    localparam logic [3:0] ADR_VECTOR = 4'h7;
    localparam logic [3:0] ADR_CPUVIEW = 4'h8;

    // =====================================================================
    // Field positions
    localparam int BIT_MODE_HIGH = 5;
    localparam int BIT_MODE_LOW = 4;
    localparam int BIT_EV_NMI = 0;
    localparam int BIT_EV_IRQ = 1;
    localparam int BIT_EV_HELD = 2;
    localparam int BIT_EV_BADMODE = 3;

    // =====================================================================
    // Reset values
    localparam logic [7:0] RST_SYSCTL = 8'h00;
    localparam logic [7:0] RST_PRI = 8'h77;
    localparam logic [11:0] RST_EN = 12'h000;
    localparam logic [3:0] RST_EV = 4'h0;

    // Vector number of a source index
    function automatic logic [7:0] ipmc_vec_of(input logic [3:0] idx);
        if (idx < SRC_SCI0_BASE) begin
            ipmc_vec_of = VEC_DMA_BASE + 8'(idx[1:0]);
        end else if (idx < SRC_SCI1_BASE) begin
            ipmc_vec_of = VEC_SCI0_BASE + 8'(idx[1:0]);
        end else begin
            ipmc_vec_of = VEC_SCI1_BASE + 8'(idx[1:0]);
        end
    endfunction : ipmc_vec_of

endpackage : ipmc_pkg

//--- core/ipmc_arb_if.sv
// Interface between the controller top and its priority arbiter
// Assumes both ends sit in the system clock domain
`timescale 1ns/1ps
interface ipmc_arb_if;
    logic [11:0] req;
    logic [2:0] lvl_dma;
    logic [2:0] lvl_sci0;
    logic [2:0] lvl_sci1;
    logic flat;
    logic hit;
    logic [3:0] idx;
    logic [2:0] lvl;
    modport arb (input req, input lvl_dma, input lvl_sci0, input lvl_sci1, input flat,
                 output hit, output idx, output lvl);
    modport ctl (output req, output lvl_dma, output lvl_sci0, output lvl_sci1, output flat,
                 input hit, input idx, input lvl);
endinterface : ipmc_arb_if

//--- core/ipmc_arbiter.sv
// Combinational priority arbiter over the twelve enabled sources
// Assumes requests are already gated by their enables
`timescale 1ns/1ps
module ipmc_arbiter
    import ipmc_pkg::*;
(
    ipmc_arb_if.arb bus
);
    logic [2:0] src_lvl [NSRC];

    // =====================================================================
    // Per-source level fan-out
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_lvl
            if (g < 4) begin : g_dma
                assign src_lvl[g] = bus.flat ? LVL_FLAT : bus.lvl_dma;
            end else if (g < 8) begin : g_s0
                assign src_lvl[g] = bus.flat ? LVL_FLAT : bus.lvl_sci0;
            end else begin : g_s1
                assign src_lvl[g] = bus.flat ? LVL_FLAT : bus.lvl_sci1;
            end
        end
    endgenerate

    // =====================================================================
    // Highest level wins, lower index wins ties
    always_comb begin
        bus.hit = 1'b0;
        bus.idx = 4'h0;
        bus.lvl = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (bus.req[i] && (!bus.hit || src_lvl[i] >= bus.lvl)) begin
                bus.hit = 1'b1;
                bus.idx = 4'(i);
                bus.lvl = src_lvl[i];
            end
        end
    end

endmodule : ipmc_arbiter

//--- tb/ipmc_cpu_model.sv
// CPU core stand-in: holds the global mask flag and mask level, ties the user bit low
// Assumes the mclk_i domain; the bench loads a mask or lets a take raise it
`timescale 1ns/1ps
module ipmc_cpu_model (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic glob_i,
    input wire logic [2:0] lvl_i,
    input wire logic take_i,
    input wire logic irq_req_i,
    input wire logic nmi_req_i,
    input wire logic [2:0] irq_level_i,
    output logic cpu_global_mask_o,
    output logic cpu_user_bit_o,
    output logic [2:0] cpu_mask_level_o
);
    // =====================================================================
    // Mask state; a taken request masks and sets the level to its own
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cpu_global_mask_o <= 1'b0;
            cpu_mask_level_o <= 3'h0;
        end else if (load_i) begin
            cpu_global_mask_o <= glob_i;
            cpu_mask_level_o <= lvl_i;
        end else if (take_i && (irq_req_i || nmi_req_i)) begin
            cpu_global_mask_o <= 1'b1;
            cpu_mask_level_o <= irq_level_i;
        end
    end

    assign cpu_user_bit_o = 1'b0;

endmodule : ipmc_cpu_model

//--- tb/interrupt_priority_mode_control_bench.sv
// Self-checking bench for the interrupt priority and mode controller
// Assumes ipmc_pkg, ipmc_top and the CPU stand-in are compiled first
`timescale 1ns/1ps
module interrupt_priority_mode_control_bench import ipmc_pkg::*;;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [11:0] src = 12'h000;
    logic nmi = 1'b0;
    logic stby = 1'b0;
    logic lng = 1'b0;
    logic load = 1'b0;
    logic glob = 1'b0;
    logic take = 1'b0;
    logic [2:0] lvl = 3'h0;
    logic gm, ub, irq, nmiq, int_w;
    logic [2:0] ml, ilvl;
    logic [7:0] rdata, vec, d;
    logic [15:0] va;
    int mismatches = 0;
    int total_checks = 0;

    always #50 mclk_i = ~mclk_i;

    ipmc_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .dma_ch0a_done_i(src[0]), .dma_ch0b_done_i(src[1]), .dma_ch1a_done_i(src[2]),
        .dma_ch1b_done_i(src[3]), .serial0_rx_error_i(src[4]),
        .serial0_rx_full_i(src[5]), .serial0_tx_empty_i(src[6]),
        .serial0_tx_done_i(src[7]), .serial1_rx_error_i(src[8]),
        .serial1_rx_full_i(src[9]), .serial1_tx_empty_i(src[10]),
        .serial1_tx_done_i(src[11]), .nmi_pin_i(nmi), .hw_standby_i(stby),
        .cpu_global_mask_i(gm), .cpu_user_bit_i(ub), .cpu_mask_level_i(ml),
        .long_addr_mode_i(lng), .irq_req_o(irq), .irq_vector_o(vec),
        .irq_level_o(ilvl), .vec_addr_o(va), .nmi_req_o(nmiq), .int_o(int_w));

    ipmc_cpu_model cpu (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .load_i(load),
        .glob_i(glob), .lvl_i(lvl), .take_i(take), .irq_req_i(irq), .nmi_req_i(nmiq),
        .irq_level_i(ilvl), .cpu_global_mask_o(gm), .cpu_user_bit_o(ub),
        .cpu_mask_level_o(ml));

    // =====================================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : wt

    task automatic wreg(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        @(negedge mclk_i);
        v = rdata;
    endtask : rreg

    task automatic drive(input logic [11:0] s);
        @(posedge mclk_i);
        src <= s;
        wt(2);
    endtask : drive

    task automatic set_mask(input logic g, input logic [2:0] l);
        @(posedge mclk_i);
        glob <= g;
        lvl <= l;
        load <= 1'b1;
        @(posedge mclk_i);
        load <= 1'b0;
        wt(2);
    endtask : set_mask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // =====================================================================
    // Scenarios
    task automatic t_regs;
        rreg(ADR_PRI10, d);
        chk(16'(d), 16'(RST_PRI));
        rreg(ADR_SYSCTL, d);
        chk(16'(d), 16'(RST_SYSCTL));
        wreg(4'hF, 8'hFF);
        rreg(4'hF, d);
        chk(16'(d), 16'h0000);
        chk(16'(irq), 16'h0000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_vectors;
        logic [7:0] e;
        wreg(ADR_EN_LO, 8'hFF);
        wreg(ADR_EN_HI, 8'h0F);
        for (int i = 0; i < 12; i++) begin
            e = (i < 4) ? 8'(72 + i) : 8'(76 + i);
            @(posedge mclk_i);
            lng <= 1'b0;
            src <= 12'h001 << i;
            wt(2);
            chk(16'(irq), 16'h0001);
            chk(16'(vec), 16'(e));
            chk(va, 16'(e) * 16'h0002);
            @(posedge mclk_i);
            lng <= 1'b1;
            wt(2);
            chk(va, 16'(e) * 16'h0004);
        end
        drive(12'h028);
        chk(16'(vec), 16'h004B);
        wreg(ADR_EN_LO, 8'hFE);
        drive(12'h001);
        chk(16'(irq), 16'h0000);
        drive(12'h003);
        chk(16'(vec), 16'h0049);
        $display("test vectors done");
    endtask : t_vectors

    task automatic t_mode0;
        drive(12'h002);
        chk(16'(irq), 16'h0001);
        chk(16'(ilvl), 16'h0000);
        set_mask(1'b1, 3'h0);
        chk(16'(irq), 16'h0000);
        set_mask(1'b0, 3'h7);
        chk(16'(irq), 16'h0001);
        $display("test mode0 done");
    endtask : t_mode0

    task automatic t_mode2;
        wreg(ADR_EN_LO, 8'hFF);
        wreg(ADR_SYSCTL, 8'h20);
        wreg(ADR_PRI10, 8'h35);
        wreg(ADR_PRI11, 8'h60);
        set_mask(1'b0, 3'h4);
        drive(12'h011);
        chk(16'(vec), 16'h0050);
        chk(16'(ilvl), 16'h0005);
        set_mask(1'b0, 3'h5);
        chk(16'(irq), 16'h0000);
        set_mask(1'b1, 3'h4);
        chk(16'(irq), 16'h0001);
        set_mask(1'b0, 3'h5);
        drive(12'h111);
        chk(16'(vec), 16'h0054);
        chk(16'(ilvl), 16'h0006);
        rreg(ADR_VECTOR, d);
        chk(16'(d), 16'h0054);
        rreg(ADR_CPUVIEW, d);
        chk(16'(d), 16'h0025);
        @(posedge mclk_i);
        take <= 1'b1;
        @(posedge mclk_i);
        take <= 1'b0;
        wt(2);
        chk(16'(irq), 16'h0000);
        wreg(ADR_PRI10, 8'h77);
        wreg(ADR_PRI11, 8'h70);
        set_mask(1'b0, 3'h0);
        drive(12'h120);
        chk(16'(vec), 16'h0051);
        $display("test mode2 done");
    endtask : t_mode2

    task automatic t_nmi;
        set_mask(1'b1, 3'h7);
        drive(12'h000);
        @(posedge mclk_i);
        nmi <= 1'b1;
        wt(4);
        chk(16'(nmiq), 16'h0001);
        chk(16'(vec), 16'(VEC_NMI));
        @(posedge mclk_i);
        stby <= 1'b1;
        wt(4);
        chk(16'(nmiq), 16'h0000);
        @(posedge mclk_i);
        stby <= 1'b0;
        sys_rst_i <= 1'b1;
        wt(4);
        chk(16'(nmiq), 16'h0000);
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        wt(4);
        chk(16'(nmiq), 16'h0001);
        @(posedge mclk_i);
        nmi <= 1'b0;
        wt(4);
        $display("test nmi done");
    endtask : t_nmi

    task automatic t_int;
        wreg(ADR_EN_LO, 8'h01);
        rreg(ADR_STATUS, d);
        wreg(ADR_MASK, 8'h01);
        drive(12'h001);
        chk(16'(int_w), 16'h0000);
        wreg(ADR_MASK, 8'h02);
        wt(2);
        chk(16'(int_w), 16'h0001);
        rreg(ADR_STATUS, d);
        chk(16'(d & 8'h02), 16'h0002);
        wt(2);
        chk(16'(int_w), 16'h0000);
        $display("test int done");
    endtask : t_int

    // =====================================================================
    // Sequence and hang guard
    initial begin
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_vectors();
        t_mode0();
        t_mode2();
        t_nmi();
        t_int();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        $display("timeout");
        end_of_test();
    end

endmodule : interrupt_priority_mode_control_bench
